// *** inc/acsf_defs.svh ***
/*
 * Constants of the ASCII command slave framer: characters, frame limits,
 * field positions, error codes and reset values.
 * Assumes it is included by bare name by every file that needs it.
 */
//
// Contract
// R1 - Execute complete command, then send response
// R2 - Every character travels as ASCII byte
// R3 - Host sends first; turns then alternate
// R4 - Command opens with percent or less-than
// R5 - Two-character destination unit follows header
// R6 - Host writes command text upper-case only
// R7 - XOR check over header through text
// R8 - Two asterisks skip the check
// R9 - Carriage return ends every frame
// R10 - Percent frame 118, less-than 2048 characters
// R11 - Response header copies command header
// R12 - Response carries own unit number
// R13 - Dollar on success, bang plus error
// R14 - Echo unit and command name unchanged
// R15 - Read and write contacts, three addressings
// R16 - Data, timer preset, timer elapsed commands
// R17 - Register watch items, report on start
// R18 - Fill contacts pattern and data ranges
// R19 - System config, state, mode, abort commands
// R20 - Unit 1 to 99; switch overrides
// R21 - Stored unit used only while switch zero
// R22 - Answer only when destination matches unit
// R23 - Check sent as two hex characters
`ifndef ACSF_DEFS_SVH
`define ACSF_DEFS_SVH

// ****************************************************************
// Characters
// ****************************************************************
`define ACSF_HDR_STD 8'h25
`define ACSF_HDR_EXT 8'h3c
`define ACSF_CHR_CR 8'h0d
`define ACSF_CHR_SKIP 8'h2a
`define ACSF_CHR_OK 8'h24
`define ACSF_CHR_NG 8'h21
`define ACSF_CHR_CMD 8'h23
`define ACSF_CHR_ZERO 8'h30
`define ACSF_CHR_LC_A 8'h61
`define ACSF_CHR_LC_Z 8'h7a

// ****************************************************************
// Frame limits and positions (characters, CR included except in ACSF_MIN_LEN)
// ****************************************************************
`define ACSF_LIM_STD 12'h076
`define ACSF_LIM_EXT 12'h800
`define ACSF_MIN_LEN 12'h008
`define ACSF_POS_UHI 12'h001
`define ACSF_POS_ULO 12'h002
`define ACSF_POS_MARK 12'h003
`define ACSF_POS_C1 12'h004
`define ACSF_POS_C2 12'h005
`define ACSF_RSP_BODY 12'h006
`define ACSF_RSP_OVH 12'h009

// ****************************************************************
// Error codes and reset values
// ****************************************************************
`define ACSF_ERR_BCC 8'h40
`define ACSF_ERR_FMT 8'h41
`define ACSF_ERR_CMD 8'h42
`define ACSF_ERR_LEN 8'h43
`define ACSF_RST_BYTE 8'h00
`define ACSF_RST_CNT 12'h000

`endif

// *** inc/acsf_pkg.sv ***
/*
 * Types of the ASCII command slave framer: command codes and the
 * request and answer records exchanged with the command executor.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package acsf_pkg;

	// Decoded two-letter command names
	typedef enum logic [4:0] {
		CMD_NONE,
		READ_CONTACTS_CMD,
		WRITE_CONTACTS_CMD,
		READ_DATA_AREA_CMD,
		WRITE_DATA_AREA_CMD,
		READ_TIMER_PRESET_CMD,
		WRITE_TIMER_PRESET_CMD,
		READ_TIMER_ELAPSED_CMD,
		WRITE_TIMER_ELAPSED_CMD,
		REGISTER_CONTACT_WATCH_CMD,
		REGISTER_DATA_WATCH_CMD,
		WATCH_START_CMD,
		FILL_CONTACTS_CMD,
		FILL_DATA_CMD,
		READ_SYS_CONFIG_CMD,
		WRITE_SYS_CONFIG_CMD,
		READ_CONTROLLER_STATE_CMD,
		REMOTE_MODE_CMD,
		ABORT_LINK_CMD
	} acsf_cmd_e;

	// Request handed to the executor
	typedef struct packed {
		acsf_cmd_e cmd;
		logic [7:0] hdr;
		logic [11:0] len;
	} acsf_req_s;

	// Answer returned by the executor
	typedef struct packed {
		logic ok;
		logic [7:0] err;
		logic [11:0] pay_len;
	} acsf_rsp_s;

endpackage

`default_nettype wire

// *** logic/acsf_skid_buf.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and an already synchronised active-low reset.
 */
`default_nettype none

module acsf_skid_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);

	logic v0_ff, v1_ff, nxt_v0, nxt_v1;
	logic [W-1:0] d0_ff, d1_ff, nxt_d0, nxt_d1;
	logic push, pop;

	// Head entry drives the output straight from flops
	assign in_ready_o = !v1_ff;
	assign out_valid_o = v0_ff;
	assign out_data_o = d0_ff;
	assign push = in_valid_i && !v1_ff;
	assign pop = v0_ff && out_ready_i;

	// Second slot only fills while the head is stalled
	always_comb
	begin
		nxt_v0 = v0_ff;
		nxt_v1 = v1_ff;
		nxt_d0 = d0_ff;
		nxt_d1 = d1_ff;
		if (pop && v1_ff)
		begin
			nxt_d0 = d1_ff;
			nxt_v1 = push;
			nxt_d1 = in_data_i;
		end
		else if (pop || !v0_ff)
		begin
			nxt_v0 = push;
			nxt_d0 = in_data_i;
		end
		else if (push)
		begin
			nxt_v1 = 1'b1;
			nxt_d1 = in_data_i;
		end
	end

	// Storage
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			v0_ff <= 1'b0;
			v1_ff <= 1'b0;
			d0_ff <= '0;
			d1_ff <= '0;
		end
		else
		begin
			v0_ff <= nxt_v0;
			v1_ff <= nxt_v1;
			d0_ff <= nxt_d0;
			d1_ff <= nxt_d1;
		end
	end

endmodule

`default_nettype wire

// *** logic/acsf_framer.sv ***
/*
 * Slave framer of an ASCII command/response link: takes command bytes,
 * checks header, unit, check code and length, hands the decoded command
 * to an executor and sends back the framed response.
 * Assumes a byte-wide receiver and transmitter on the same clock, and an
 * executor whose payload memory answers combinationally to pay_addr_o.
 */
`default_nettype none
`include "acsf_defs.svh"

module acsf_framer #(
	parameter int FRAME_MAX = 2048,
	parameter int AW = 11
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Received characters
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// Transmitted characters
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Unit number selection
	input wire logic [6:0] unit_sw_i,
	input wire logic [6:0] unit_cfg_i,
	output logic [6:0] unit_o,
	// Executor request
	output logic exec_req_o,
	output acsf_pkg::acsf_req_s exec_o,
	input wire logic exec_done_i,
	input wire acsf_pkg::acsf_rsp_s exec_rsp_i,
	// Executor access to the command text
	input wire logic [AW-1:0] arg_addr_i,
	output logic [7:0] arg_data_o,
	// Response payload read port
	output logic [11:0] pay_addr_o,
	input wire logic [7:0] pay_data_i
);

	typedef enum logic [2:0] {ST_RECV, ST_CHECK, ST_EXEC, ST_SEND}
		acsf_state_e;

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Nibble to upper-case hex character
	function automatic logic [7:0] to_hex(input logic [3:0] n);
		to_hex = (n < 4'ha) ? (`ACSF_CHR_ZERO + {4'h0, n})
			: (8'h37 + {4'h0, n});
	endfunction

	// Hex character to nibble, bit 4 flags a bad character
	function automatic logic [4:0] from_hex(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			from_hex = {1'b0, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			from_hex = {1'b0, 4'(c - 8'h37)};
		else
			from_hex = 5'h10;
	endfunction

	// Decimal digit character to value, out of range gives 4'hf
	function automatic logic [3:0] from_dec(input logic [7:0] c);
		from_dec = (c >= 8'h30 && c <= 8'h39) ? 4'(c - 8'h30) : 4'hf;
	endfunction

	// Two command letters to a command code
	function automatic acsf_pkg::acsf_cmd_e decode(input logic [15:0] n);
		case (n)
			16'h5243: decode = acsf_pkg::READ_CONTACTS_CMD;
			16'h5743: decode = acsf_pkg::WRITE_CONTACTS_CMD;
			16'h5244: decode = acsf_pkg::READ_DATA_AREA_CMD;
			16'h5744: decode = acsf_pkg::WRITE_DATA_AREA_CMD;
			16'h5253: decode = acsf_pkg::READ_TIMER_PRESET_CMD;
			16'h5753: decode = acsf_pkg::WRITE_TIMER_PRESET_CMD;
			16'h524b: decode = acsf_pkg::READ_TIMER_ELAPSED_CMD;
			16'h574b: decode = acsf_pkg::WRITE_TIMER_ELAPSED_CMD;
			16'h4d43: decode = acsf_pkg::REGISTER_CONTACT_WATCH_CMD;
			16'h4d44: decode = acsf_pkg::REGISTER_DATA_WATCH_CMD;
			16'h4d47: decode = acsf_pkg::WATCH_START_CMD;
			16'h5343: decode = acsf_pkg::FILL_CONTACTS_CMD;
			16'h5344: decode = acsf_pkg::FILL_DATA_CMD;
			16'h5252: decode = acsf_pkg::READ_SYS_CONFIG_CMD;
			16'h5752: decode = acsf_pkg::WRITE_SYS_CONFIG_CMD;
			16'h5254: decode = acsf_pkg::READ_CONTROLLER_STATE_CMD;
			16'h524d: decode = acsf_pkg::REMOTE_MODE_CMD;
			16'h4142: decode = acsf_pkg::ABORT_LINK_CMD;
			default: decode = acsf_pkg::CMD_NONE;
		endcase
	endfunction

	// ****************************************************************
	// Reset release and unit selection
	// ****************************************************************
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [6:0] sw_meta_ff, sw_ff, unit_ff;
	logic [6:0] nxt_unit;

	assign rst_n = rst_sync_ff[1];

	// Release is synchronised so all flops on rst_n leave reset on one edge
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	// Switch pins are asynchronous, so two flops before use
	assign nxt_unit = (sw_ff != 7'h00) ? sw_ff : unit_cfg_i; // R20 R21

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_meta_ff <= 7'h00;
			sw_ff <= 7'h00;
			unit_ff <= 7'h00;
		end
		else
		begin
			sw_meta_ff <= unit_sw_i;
			sw_ff <= sw_meta_ff;
			unit_ff <= nxt_unit;
		end
	end

	assign unit_o = unit_ff;

	// ****************************************************************
	// Receive side
	// ****************************************************************
	acsf_state_e state_ff, nxt_state;
	logic [7:0] frame_mem [FRAME_MAX];
	logic [11:0] cnt_ff, nxt_cnt;
	logic [7:0] hdr_ff, uhi_ff, ulo_ff, mark_ff, c1_ff, c2_ff;
	logic [7:0] sh1_ff, sh2_ff, xa_ff;
	logic lc_ff, nxt_lc;
	logic take, is_hdr, is_cr, is_lc, in_frame, store;
	logic [7:0] arg_ff;

	assign take = rx_valid_i && rx_ready_o;
	assign in_frame = cnt_ff != `ACSF_RST_CNT;
	assign is_hdr = rx_data_i == `ACSF_HDR_STD
		|| rx_data_i == `ACSF_HDR_EXT; // R4
	assign is_cr = rx_data_i == `ACSF_CHR_CR; // R9
	assign is_lc = rx_data_i >= `ACSF_CHR_LC_A
		&& rx_data_i <= `ACSF_CHR_LC_Z; // R6
	assign store = take && !is_cr && (in_frame || is_hdr)
		&& cnt_ff < 12'(FRAME_MAX);
	assign nxt_lc = (take && in_frame && !is_cr && is_lc) ? 1'b1
		: ((take && !in_frame) ? 1'b0 : lc_ff);

	// Characters before a header are noise and are dropped
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (take && !is_cr && (in_frame || is_hdr)
			&& cnt_ff != 12'hfff)
			nxt_cnt = cnt_ff + 12'h001;
		else if (state_ff == ST_CHECK)
			nxt_cnt = `ACSF_RST_CNT;
	end

	// Frame text kept so the executor can parse the arguments
	always_ff @(posedge clk_sys_i)
	begin
		if (store)
			frame_mem[AW'(cnt_ff)] <= rx_data_i;
		arg_ff <= frame_mem[arg_addr_i];
	end

	assign arg_data_o = arg_ff;

	// Field capture and check code; last two bytes held back
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= `ACSF_RST_CNT;
			{hdr_ff, uhi_ff, ulo_ff} <= {3{`ACSF_RST_BYTE}};
			{mark_ff, c1_ff, c2_ff} <= {3{`ACSF_RST_BYTE}};
			{sh1_ff, sh2_ff, xa_ff} <= {3{`ACSF_RST_BYTE}};
			lc_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			lc_ff <= nxt_lc;
			if (take && !in_frame && is_hdr)
			begin
				hdr_ff <= rx_data_i;
				{sh1_ff, sh2_ff, xa_ff} <= {rx_data_i, 16'h0000}; // R7
			end
			else if (take && in_frame && !is_cr)
			begin
				xa_ff <= xa_ff ^ sh2_ff; // R7
				sh2_ff <= sh1_ff;
				sh1_ff <= rx_data_i;
				if (cnt_ff == `ACSF_POS_UHI)
					uhi_ff <= rx_data_i; // R5
				if (cnt_ff == `ACSF_POS_ULO)
					ulo_ff <= rx_data_i;
				if (cnt_ff == `ACSF_POS_MARK)
					mark_ff <= rx_data_i;
				if (cnt_ff == `ACSF_POS_C1)
					c1_ff <= rx_data_i;
				if (cnt_ff == `ACSF_POS_C2)
					c2_ff <= rx_data_i;
			end
		end
	end

	// ****************************************************************
	// Frame check
	// ****************************************************************
	logic [3:0] dhi, dlo;
	logic [6:0] dest;
	logic [4:0] bh, bl;
	logic unit_hit, bcc_ok, len_bad, fmt_bad, silent;
	logic [11:0] lim, tot;
	acsf_pkg::acsf_cmd_e cmd_dec;
	logic [7:0] chk_err;

	assign dhi = from_dec(uhi_ff);
	assign dlo = from_dec(ulo_ff);
	assign dest = 7'(dhi * 4'ha) + {3'b000, dlo};
	assign unit_hit = dhi != 4'hf && dlo != 4'hf
		&& dest == unit_ff; // R22
	assign bh = from_hex(sh2_ff);
	assign bl = from_hex(sh1_ff);
	assign bcc_ok = (sh2_ff == `ACSF_CHR_SKIP && sh1_ff == `ACSF_CHR_SKIP)
		|| (!bh[4] && !bl[4] && {bh[3:0], bl[3:0]} == xa_ff); // R8 R23
	assign lim = (hdr_ff == `ACSF_HDR_EXT) ? `ACSF_LIM_EXT
		: `ACSF_LIM_STD; // R10
	assign tot = (cnt_ff == 12'hfff) ? cnt_ff : cnt_ff + 12'h001;
	assign len_bad = tot > lim; // R10
	assign fmt_bad = cnt_ff < `ACSF_MIN_LEN || lc_ff
		|| mark_ff != `ACSF_CHR_CMD;
	assign cmd_dec = decode({c1_ff, c2_ff});
	assign silent = cnt_ff <= `ACSF_POS_ULO || !unit_hit; // R22

	// Length first, then check code, then layout, then the name
	assign chk_err = len_bad ? `ACSF_ERR_LEN
		: (!bcc_ok ? `ACSF_ERR_BCC
		: (fmt_bad ? `ACSF_ERR_FMT
		: ((cmd_dec == acsf_pkg::CMD_NONE) ? `ACSF_ERR_CMD
		: `ACSF_RST_BYTE))); // R23

	// ****************************************************************
	// Execution and response
	// ****************************************************************
	logic ok_ff, req_ff, rdy_ff;
	logic [7:0] err_ff, bx_ff, tx_byte;
	logic [11:0] pos_ff, body_ff, pay_ff, pay_max;
	acsf_pkg::acsf_req_s xreq_ff;
	logic buf_ready, push, in_body, last;
	logic [3:0] own_hi, own_lo;

	assign own_hi = 4'(unit_ff / 7'd10);
	assign own_lo = 4'(unit_ff % 7'd10);
	assign pay_max = lim - `ACSF_RSP_OVH;
	assign in_body = pos_ff < body_ff;
	assign push = state_ff == ST_SEND && buf_ready;
	assign last = pos_ff == body_ff + 12'h002;

	// Response character at the current position
	always_comb
	begin
		tx_byte = `ACSF_CHR_CR; // R9
		if (pos_ff == 12'h000)
			tx_byte = hdr_ff; // R11
		else if (pos_ff == `ACSF_POS_UHI)
			tx_byte = `ACSF_CHR_ZERO + {4'h0, own_hi}; // R12 R14
		else if (pos_ff == `ACSF_POS_ULO)
			tx_byte = `ACSF_CHR_ZERO + {4'h0, own_lo};
		else if (pos_ff == `ACSF_POS_MARK)
			tx_byte = ok_ff ? `ACSF_CHR_OK : `ACSF_CHR_NG; // R13
		else if (pos_ff == `ACSF_POS_C1)
			tx_byte = c1_ff; // R14
		else if (pos_ff == `ACSF_POS_C2)
			tx_byte = c2_ff;
		else if (in_body)
			tx_byte = ok_ff ? pay_data_i
				: to_hex(pos_ff == `ACSF_RSP_BODY ? err_ff[7:4]
				: err_ff[3:0]); // R13
		else if (pos_ff == body_ff)
			tx_byte = to_hex(bx_ff[7:4]); // R23
		else if (pos_ff == body_ff + 12'h001)
			tx_byte = to_hex(bx_ff[3:0]);
	end

	// Host speaks first; no command is taken while answering
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RECV:
				if (take && is_cr && in_frame)
					nxt_state = ST_CHECK; // R3
			ST_CHECK:
				if (silent)
					nxt_state = ST_RECV;
				else if (chk_err != `ACSF_RST_BYTE)
					nxt_state = ST_SEND;
				else
					nxt_state = ST_EXEC; // R1
			ST_EXEC:
				if (exec_done_i)
					nxt_state = ST_SEND;
			ST_SEND:
				if (push && last)
					nxt_state = ST_RECV; // R3
			default:
				nxt_state = ST_RECV;
		endcase
	end

	// Sequencer, executor handshake and running response check code
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_RECV;
			{ok_ff, req_ff, rdy_ff} <= 3'b000;
			{err_ff, bx_ff} <= {2{`ACSF_RST_BYTE}};
			{pos_ff, body_ff, pay_ff} <= {3{`ACSF_RST_CNT}};
			xreq_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			rdy_ff <= nxt_state == ST_RECV; // R3
			req_ff <= state_ff == ST_CHECK && nxt_state == ST_EXEC; // R1
			if (state_ff == ST_CHECK)
			begin
				ok_ff <= 1'b0;
				err_ff <= chk_err;
				body_ff <= `ACSF_RSP_BODY + 12'h002;
				xreq_ff <= '{cmd: cmd_dec, hdr: hdr_ff,
					len: cnt_ff}; // R15 R16 R17 R18 R19
			end
			if (state_ff == ST_EXEC && exec_done_i)
			begin
				ok_ff <= exec_rsp_i.ok; // R13
				err_ff <= exec_rsp_i.err;
				body_ff <= `ACSF_RSP_BODY + (!exec_rsp_i.ok ? 12'h002
					: ((exec_rsp_i.pay_len > pay_max) ? pay_max
					: exec_rsp_i.pay_len)); // R10
			end
			if (state_ff != ST_SEND)
			begin
				pos_ff <= `ACSF_RST_CNT;
				pay_ff <= `ACSF_RST_CNT;
				bx_ff <= `ACSF_RST_BYTE;
			end
			else if (push)
			begin
				pos_ff <= pos_ff + 12'h001;
				if (in_body)
					bx_ff <= bx_ff ^ tx_byte; // R7
				if (ok_ff && in_body && pos_ff >= `ACSF_RSP_BODY)
					pay_ff <= pay_ff + 12'h001;
			end
		end
	end

	assign rx_ready_o = rdy_ff;
	assign exec_req_o = req_ff;
	assign exec_o = xreq_ff;
	assign pay_addr_o = pay_ff;

	// A stalled transmitter backs up here and holds the sequencer
	acsf_skid_buf #(
		.W(8)
	) u_txbuf (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n),
		.in_valid_i(state_ff == ST_SEND),
		.in_data_i(tx_byte),
		.in_ready_o(buf_ready),
		.out_valid_o(tx_valid_o),
		.out_data_o(tx_data_o),
		.out_ready_i(tx_ready_i)
	); // R2

endmodule

`default_nettype wire

// *** testbench/acsf_framer_sva.sv ***
/*
 * Port checker of the ASCII command slave framer.
 * Assumes it is bound to acsf_framer and the package is compiled first.
 */
`default_nettype none
`include "acsf_defs.svh"

module acsf_framer_sva (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// Character streams
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Unit selection and executor
	input wire logic [6:0] unit_sw_i,
	input wire logic [6:0] unit_cfg_i,
	input wire logic [6:0] unit_o,
	input wire logic exec_req_o,
	input wire acsf_pkg::acsf_req_s exec_o
);
	// ********
	// Frame tracking
	// ********
	wire logic take_w = rx_valid_i && rx_ready_o;
	wire logic cr_w = take_w && rx_data_i == `ACSF_CHR_CR;
	wire logic hdr_w = take_w && (rx_data_i == `ACSF_HDR_STD ||
		rx_data_i == `ACSF_HDR_EXT);
	logic open_ff;

	// Open from a header to its CR, so a stray CR is not counted
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			open_ff <= 1'b0;
		else if (cr_w || hdr_w)
			open_ff <= hdr_w;
	end

	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	a_req_one_pulse:
	assert property (exec_req_o |=> !exec_req_o)
		else $error("executor request longer than one cycle");
	a_req_after_cr:
	assert property (exec_req_o |-> $past(cr_w, 2))
		else $error("executor request not two cycles after end char");
	a_busy_on_req:
	assert property (exec_req_o |-> !rx_ready_o)
		else $error("receiver open while command executes");
	a_cr_closes:
	assert property (open_ff && cr_w |=> !rx_ready_o)
		else $error("receiver still open after end char");
	a_req_stable:
	assert property (exec_req_o |=> $stable(exec_o) [*4])
		else $error("command record moved under the executor");
	a_tx_held:
	assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o))
		else $error("response char lost during stall");
	a_switch_wins:
	assert property ((unit_sw_i != 7'h00 && $stable(unit_sw_i)) [*8] |->
		unit_o == unit_sw_i)
		else $error("nonzero switch not used as unit");
	a_stored_unit:
	assert property ((unit_sw_i == 7'h00 && $stable(unit_cfg_i)) [*8] |->
		unit_o == unit_cfg_i)
		else $error("stored unit not used with switch at zero");
endmodule

bind acsf_framer acsf_framer_sva u_sva (
	.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid_i),
	.rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
	.tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .unit_sw_i(unit_sw_i),
	.unit_cfg_i(unit_cfg_i), .unit_o(unit_o), .exec_req_o(exec_req_o),
	.exec_o(exec_o)
);

`default_nettype wire

// *** testbench/acsf_host_model.sv ***
/*
 * Host side of the link: sends queued command chars and takes response
 * chars, stalling at random when asked.
 * Assumes the bench fills q only after the previous answer has ended.
 */
`default_nettype none

module acsf_host_model (
	// Clock and stall request
	input wire logic clk_i,
	input wire logic stall_i,
	// Command chars toward the framer
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic rx_ready_i,
	// Response chars from the framer
	output logic tx_ready_o
);
	// ********
	// Serialiser
	// ********
	logic [7:0] q[$];

	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b1;
	end

	// Hold each char until taken; idle data toggles so it never looks valid
	always @(posedge clk_i)
	begin
		if (rx_valid_o && rx_ready_i)
			void'(q.pop_front());
		#1;
		rx_valid_o = q.size() != 0;
		rx_data_o = rx_valid_o ? q[0] : ~rx_data_o;
		tx_ready_o = !stall_i || $urandom_range(1);
	end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench of the framer: executor and answer checking here.
 * Assumes the package and the host model are compiled first.
 */
`default_nettype none
`include "acsf_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Signals
	// ********
	localparam logic [7:0] HS = `ACSF_HDR_STD;
	localparam logic [7:0] HE = `ACSF_HDR_EXT;
	localparam logic [15:0] U1 = 16'h3031;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, exec_req;
	logic exec_done = 1'b0;
	logic stall = 1'b0;
	logic ex_ok = 1'b1;
	logic [7:0] rx_data, tx_data, arg_data, pay_data, c1_exp, hdr_exp;
	logic [7:0] ex_err = 8'h00;
	logic [6:0] unit_sw = 7'h00;
	logic [6:0] unit_cfg = 7'h01;
	logic [11:0] pay_addr, len_exp;
	logic [11:0] ex_len = 12'h000;
	logic [10:0] arg_addr = 11'h004;
	acsf_pkg::acsf_req_s exec;
	acsf_pkg::acsf_rsp_s exec_rsp = '0;
	logic [7:0] exp_q[$];
	acsf_pkg::acsf_cmd_e cmd_q[$];
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int exp_unit = 1;
	logic [15:0] names[18] = '{16'h5243, 16'h5743, 16'h5244, 16'h5744,
		16'h5253, 16'h5753, 16'h524b, 16'h574b, 16'h4d43, 16'h4d44, 16'h4d47,
		16'h5343, 16'h5344, 16'h5252, 16'h5752, 16'h5254, 16'h524d, 16'h4142};

	initial
	begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	acsf_host_model u_host (.clk_i(clk_sys_i), .stall_i(stall),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
		.tx_ready_o(tx_ready));

	acsf_framer dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
		.unit_sw_i(unit_sw), .unit_cfg_i(unit_cfg), .unit_o(),
		.exec_req_o(exec_req), .exec_o(exec), .exec_done_i(exec_done),
		.exec_rsp_i(exec_rsp), .arg_addr_i(arg_addr), .arg_data_o(arg_data),
		.pay_addr_o(pay_addr), .pay_data_i(pay_data));

	// Payload memory answers at once, chars 8'h41 to 8'h60 only
	assign pay_data = 8'h41 + {3'h0, pay_addr[4:0]};

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: char %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_cmd(input acsf_pkg::acsf_cmd_e got, exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: cmd %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic chk_len(input logic [11:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: length %0d want %0d", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] hexc(input logic [3:0] n);
		return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction

	task results;
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Cycle ceiling, and each taken char against the oldest note
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			n_errors++;
			results();
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			chk_byte(tx_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	end

	// Executor: peeks at the first letter, answers one cycle later
	always @(posedge clk_sys_i)
	begin
		if (exec_req === 1'b1)
		begin
			chk_cmd(exec.cmd, cmd_q.pop_front());
			chk_byte(exec.hdr, hdr_exp);
			chk_len(exec.len, len_exp);
			@(posedge clk_sys_i);
			chk_byte(arg_data, c1_exp);
			#1;
			exec_rsp = {ex_ok, ex_err, ex_len};
			exec_done = 1'b1;
			@(posedge clk_sys_i);
			#1;
			exec_done = 1'b0;
		end
	end

	// One exchange; ec 8'hff means no answer is due
	task automatic send(input logic [7:0] h, input logic [15:0] u, c,
		input int nt, bm, input logic [7:0] ec, input acsf_pkg::acsf_cmd_e ce);
		logic [7:0] f[$];
		logic [7:0] x;
		int k, pl;
		f = {8'h20, h, u[15:8], u[7:0], `ACSF_CHR_CMD, c[15:8], c[7:0]};
		repeat (nt) f.push_back(8'h41 + 8'($urandom_range(25)));
		x = 8'h20;
		foreach (f[i]) x ^= f[i];
		f.push_back(bm == 1 ? `ACSF_CHR_SKIP : hexc(x[7:4]));
		f.push_back(bm == 1 ? `ACSF_CHR_SKIP : hexc(bm == 2 ? ~x[3:0] : x[3:0]));
		f.push_back(`ACSF_CHR_CR);
		c1_exp = c[15:8];
		hdr_exp = h;
		len_exp = 12'(nt + 8);
		foreach (f[i]) u_host.q.push_back(f[i]);
		if (ec == 8'h00)
			cmd_q.push_back(ce);
		if (ec != 8'hff)
		begin
			f = {h, 8'(8'h30 + exp_unit / 10), 8'(8'h30 + exp_unit % 10),
				ec == 8'h00 && ex_ok ? `ACSF_CHR_OK : `ACSF_CHR_NG, c[15:8], c[7:0]};
			x = ec == 8'h00 ? ex_err : ec;
			// Payload is cut so the whole response fits the frame limit
			pl = (h == HS ? 118 : 2048) - 9;
			if (ex_len < pl)
				pl = ex_len;
			if (ec == 8'h00 && ex_ok)
				for (k = 0; k < pl; k++) f.push_back(8'h41 + 8'(k % 32));
			else
				f = {f, hexc(x[7:4]), hexc(x[3:0])};
			x = 8'h00;
			foreach (f[i]) x ^= f[i];
			f = {f, hexc(x[7:4]), hexc(x[3:0]), `ACSF_CHR_CR};
			foreach (f[i]) exp_q.push_back(f[i]);
		end
		k = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1;
			k++;
		end while ((u_host.q.size() || exp_q.size() || rx_ready !== 1'b1)
			&& k < 6000);
		if (k >= 6000)
			n_errors++;
	endtask

	initial
	begin
		void'($urandom(32'h4adb));
		repeat (10) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		#1;
		// Whole command set, both headers, skipped check, transmitter stalls
		for (int i = 0; i < 18; i++)
		begin
			stall = i[1];
			ex_len = 12'($urandom_range(20));
			send(i[0] ? HE : HS, U1, names[i], $urandom_range(8), i % 3 == 2,
				8'h00, acsf_pkg::acsf_cmd_e'(5'(i + 1)));
		end
		// Executor failure: its code goes out as two hex chars
		ex_ok = 1'b0;
		ex_err = 8'($urandom);
		send(HS, U1, names[2], 3, 0, 8'h00, acsf_pkg::READ_DATA_AREA_CMD);
		ex_ok = 1'b1;
		// Errors the framer answers by itself
		send(HS, U1, names[0], 2, 2, `ACSF_ERR_BCC, acsf_pkg::CMD_NONE);
		send(HE, U1, 16'h7263, 1, 0, `ACSF_ERR_FMT, acsf_pkg::CMD_NONE);
		send(HS, U1, 16'h5a5a, 0, 0, `ACSF_ERR_CMD, acsf_pkg::CMD_NONE);
		// Frame lengths at and just past each limit, long answers clamped
		ex_len = 12'h0c8;
		send(HS, U1, names[1], 109, 0, 8'h00,
			acsf_pkg::WRITE_CONTACTS_CMD);
		send(HS, U1, names[1], 110, 0, `ACSF_ERR_LEN, acsf_pkg::CMD_NONE);
		send(HE, U1, names[1], 2039, 0, 8'h00,
			acsf_pkg::WRITE_CONTACTS_CMD);
		send(HE, U1, names[1], 2040, 1, `ACSF_ERR_LEN, acsf_pkg::CMD_NONE);
		// Another unit's command stays unanswered
		send(HS, 16'h3032, names[0], 0, 0, 8'hff, acsf_pkg::CMD_NONE);
		// Switch overrides the stored number, then the stored one returns
		unit_sw = 7'h05;
		repeat (10) @(posedge clk_sys_i);
		#1 exp_unit = 5;
		send(HS, 16'h3035, names[3], 1, 0, 8'h00,
			acsf_pkg::WRITE_DATA_AREA_CMD);
		send(HS, U1, names[3], 1, 0, 8'hff, acsf_pkg::CMD_NONE);
		unit_sw = 7'h00;
		unit_cfg = 7'h17;
		repeat (10) @(posedge clk_sys_i);
		#1 exp_unit = 23;
		send(HE, 16'h3233, names[4], 1, 0, 8'h00,
			acsf_pkg::READ_TIMER_PRESET_CMD);
		results();
	end
endmodule

`default_nettype wire
